// ### rtl/sram_wr_defs.svh
`ifndef SRAM_WR_DEFS_SVH
`define SRAM_WR_DEFS_SVH

// ---------------------------------------------------------------------------
// Widths and counts
// ---------------------------------------------------------------------------
`define DATA_W        36
`define ADDR_W        20
`define LANE_W        9
`define LANE_N        4
`define NIBBLE_W      4
`define BEAT_W        2
`define BURST_LAST    2'h3
`define FIFO_DEPTH    8
`define PAYLOAD_W     94

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
// Idle levels of in_clk, in_clk_n and the write select, in that order.
`define PIN_IDLE_HEAD 3'h3

// ---------------------------------------------------------------------------
// Width configuration codes
// ---------------------------------------------------------------------------
`define CFG_X8        2'h0
`define CFG_X9        2'h1
`define CFG_X18       2'h2
`define CFG_X36       2'h3

`endif

// ### rtl/sram_wr_pkg.sv
package sram_wr_pkg;
  typedef enum logic [1:0] {
    WIDTH_X8,
    WIDTH_X9,
    WIDTH_X18,
    WIDTH_X36
  } width_cfg_type;

  typedef enum logic {
    WR_IDLE,
    WR_BURST
  } wr_state_type;
endpackage

// ### rtl/sram_write_port_masking.sv
// Function
// - Write data captured on rising edges of both input clocks, up to 36 bits.
// - Active-low write port select sampled on positive clock edge starts a write.
// - Select sampled high deselects the port; data inputs are ignored.
// - In x8 mode two nibble masks govern bits 3..0 and 7..4.
// - Nibble masks sampled on the same edge as the data word they qualify.
// - A high nibble mask discards that nibble; it is never written.
// - Byte masks govern nine-bit lanes according to the x9, x18 or x36 width.
// - Byte masks sampled on both clock edges only while a write is active.
// - A high byte mask leaves that lane of the stored word unchanged.
// - Address sampled on positive clock edge; ignored while the port is deselected.
// - Every write starts on a rising edge of the positive input clock.
`timescale 1ns/100ps
`include "sram_wr_defs.svh"

// ---------------------------------------------------------------------------
// Write word buffer
// ---------------------------------------------------------------------------
module sram_wr_fifo #(
  parameter int WIDTH = `PAYLOAD_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  // One spare pointer bit tells a full buffer from an empty one.
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic [PW:0]      next_wr_ptr;
  logic [PW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wr_ptr - rd_ptr) != (PW+1)'(DEPTH);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem[rd_ptr[PW-1:0]];

  always_comb begin
    next_wr_ptr = wr_ptr + (PW+1)'(push);
    next_rd_ptr = rd_ptr + (PW+1)'(pop);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage has no reset so it maps onto plain RAM cells.
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr[PW-1:0]] <= in_data_i;
    end
  end
endmodule

// ---------------------------------------------------------------------------
// Write port input stage
// ---------------------------------------------------------------------------
module sram_write_port_masking (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  in_clk_i,
  input  wire logic                  in_clk_n_i,
  input  wire logic                  write_port_select_n_i,
  input  wire logic [`ADDR_W-1:0]    addr_i,
  input  wire logic [`DATA_W-1:0]    data_i,
  input  wire logic [1:0]            nibble_write_mask_n_i,
  input  wire logic [`LANE_N-1:0]    byte_lane_write_mask_n_i,
  input  wire logic [1:0]            width_cfg_i,
  output logic                       word_valid_o,
  input  wire logic                  word_ready_i,
  output logic      [`ADDR_W-1:0]    word_addr_o,
  output logic      [`BEAT_W-1:0]    word_beat_o,
  output logic      [`DATA_W-1:0]    word_data_o,
  output logic      [`DATA_W-1:0]    word_bit_enable_o,
  output logic                       write_busy_o,
  output logic                       overrun_o
);
  // -------------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------------
  // Everything crosses as one bundle so data, masks and clocks stay aligned.
  localparam int SW = 2 + 1 + `ADDR_W + `DATA_W + 2 + `LANE_N + 2;
  // Reset holds the idle pin levels, so release never looks like a clock edge or a select.
  // The input clocks are sampled as levels; their edges are found after the second flop.
  localparam logic [SW-1:0] PIN_IDLE = {`PIN_IDLE_HEAD, {(SW-3){1'b0}}};

  logic [SW-1:0] pin_meta;
  logic [SW-1:0] pin_sync;
  logic          k_prev;
  logic          kn_prev;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      k_prev   <= PIN_IDLE[SW-1];
      kn_prev  <= PIN_IDLE[SW-2];
    end else begin
      pin_meta <= {in_clk_i, in_clk_n_i, write_port_select_n_i, addr_i, data_i,
                   nibble_write_mask_n_i, byte_lane_write_mask_n_i, width_cfg_i};
      pin_sync <= pin_meta;
      k_prev   <= pin_sync[SW-1];
      kn_prev  <= pin_sync[SW-2];
    end
  end

  logic                 k_rise;
  logic                 kn_rise;
  logic                 sel_n;
  logic [`ADDR_W-1:0]   addr_s;
  logic [`DATA_W-1:0]   data_s;
  logic [1:0]           nib_n_s;
  logic [`LANE_N-1:0]   lane_n_s;
  sram_wr_pkg::width_cfg_type cfg;

  assign k_rise  = pin_sync[SW-1] & ~k_prev;
  assign kn_rise = pin_sync[SW-2] & ~kn_prev;
  assign {sel_n, addr_s, data_s, nib_n_s, lane_n_s} = pin_sync[SW-3:2];
  assign cfg     = sram_wr_pkg::width_cfg_type'(pin_sync[1:0]);

  // -------------------------------------------------------------------------
  // Per-bit write enables for the current word
  // -------------------------------------------------------------------------
  logic [`LANE_N-1:0] lane_present;
  logic [`DATA_W-1:0] bit_en;

  always_comb begin
    case (cfg)
      sram_wr_pkg::WIDTH_X9:  lane_present = 4'h1;
      sram_wr_pkg::WIDTH_X18: lane_present = 4'h3;
      sram_wr_pkg::WIDTH_X36: lane_present = 4'hF;
      default:                lane_present = 4'h0;
    endcase
  end

  // Masks are taken from the same sampled bundle as the data, never held over.
  // Only the two low nibbles own a nibble mask, so no mask index runs past its range.
  genvar b;
  generate
    for (b = 0; b < `DATA_W; b++) begin : g_bit
      logic lane_on;

      assign lane_on = lane_present[b / `LANE_W] && !lane_n_s[b / `LANE_W];

      if (b < 2 * `NIBBLE_W) begin : g_nibble
        always_comb begin
          if (cfg == sram_wr_pkg::WIDTH_X8) begin
            bit_en[b] = !nib_n_s[b / `NIBBLE_W];
          end else begin
            bit_en[b] = lane_on;
          end
        end
      end else begin : g_wide
        // Bits above the low byte carry nothing in the x8 width.
        always_comb begin
          if (cfg == sram_wr_pkg::WIDTH_X8) begin
            bit_en[b] = 1'b0;
          end else begin
            bit_en[b] = lane_on;
          end
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------------------
  // Burst sequencer
  // -------------------------------------------------------------------------
  sram_wr_pkg::wr_state_type state;
  sram_wr_pkg::wr_state_type next_state;
  logic [`BEAT_W-1:0] beat;
  logic [`BEAT_W-1:0] next_beat;
  logic [`ADDR_W-1:0] addr_q;
  logic [`ADDR_W-1:0] next_addr_q;
  logic               word_edge;
  logic               capture;
  logic               start;

  // Beats alternate: negative edge, positive edge, negative edge, positive edge.
  // A start may share the edge of the last beat, so bursts can follow with no gap.
  assign word_edge = beat[0] ? k_rise : kn_rise;
  assign capture   = (state == sram_wr_pkg::WR_BURST) && word_edge;
  assign start     = k_rise && !sel_n &&
                     ((state == sram_wr_pkg::WR_IDLE) || (capture && beat == `BURST_LAST));

  always_comb begin
    next_state  = state;
    next_beat   = beat;
    next_addr_q = addr_q;
    case (state)
      sram_wr_pkg::WR_IDLE: begin
        next_beat = '0;
      end
      sram_wr_pkg::WR_BURST: begin
        if (capture) begin
          next_beat = beat + 2'h1;
          if (beat == `BURST_LAST) begin
            next_state = sram_wr_pkg::WR_IDLE;
          end
        end
      end
      default: begin
        next_state = sram_wr_pkg::WR_IDLE;
        next_beat  = '0;
      end
    endcase
    // A high select leaves address and data untouched.
    if (start) begin
      next_state  = sram_wr_pkg::WR_BURST;
      next_beat   = '0;
      next_addr_q = addr_s;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state  <= sram_wr_pkg::WR_IDLE;
      beat   <= '0;
      addr_q <= '0;
    end else begin
      state  <= next_state;
      beat   <= next_beat;
      addr_q <= next_addr_q;
    end
  end

  // -------------------------------------------------------------------------
  // Hand-off register and buffer
  // -------------------------------------------------------------------------
  // The external bus cannot be paused, so a word that finds the hand-off
  // stage still occupied is lost and reported rather than silently merged.
  // Overrun pulses once per lost word, so a counter outside can total the losses.
  logic                  pend_valid;
  logic                  next_pend_valid;
  logic [`PAYLOAD_W-1:0] pend_data;
  logic [`PAYLOAD_W-1:0] next_pend_data;
  logic                  fifo_ready;
  logic                  next_overrun;
  logic [`PAYLOAD_W-1:0] fifo_out;

  always_comb begin
    next_pend_valid = pend_valid && !fifo_ready;
    next_pend_data  = pend_data;
    next_overrun    = 1'b0;
    if (capture) begin
      if (next_pend_valid) begin
        next_overrun = 1'b1;
      end else begin
        next_pend_valid = 1'b1;
        next_pend_data  = {addr_q, beat, data_s & bit_en, bit_en};
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_valid <= 1'b0;
      pend_data  <= '0;
      overrun_o  <= 1'b0;
    end else begin
      pend_valid <= next_pend_valid;
      pend_data  <= next_pend_data;
      overrun_o  <= next_overrun;
    end
  end

  sram_wr_fifo #(
    .WIDTH (`PAYLOAD_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (pend_valid),
    .in_ready_o  (fifo_ready),
    .in_data_i   (pend_data),
    .out_valid_o (word_valid_o),
    .out_ready_i (word_ready_i),
    .out_data_o  (fifo_out)
  );

  assign {word_addr_o, word_beat_o, word_data_o, word_bit_enable_o} = fifo_out;
  assign write_busy_o = (state == sram_wr_pkg::WR_BURST);
endmodule

// ### verification/wr_port_props.sv
`timescale 1ns/100ps
module wr_port_props (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        in_clk_i,
  input wire logic        write_port_select_n_i,
  input wire logic [1:0]  width_cfg_i,
  input wire logic        word_valid_o,
  input wire logic        word_ready_i,
  input wire logic [19:0] word_addr_o,
  input wire logic [1:0]  word_beat_o,
  input wire logic [35:0] word_data_o,
  input wire logic [35:0] word_bit_enable_o,
  input wire logic        write_busy_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [35:0] lim;
  // The strap must stay still while words are queued, or the limit is judged too early.
  assign lim = (width_cfg_i == 2'h0) ? 36'h0_0000_00FF : (width_cfg_i == 2'h1) ? 36'h0_0000_01FF
             : (width_cfg_i == 2'h2) ? 36'h0_0003_FFFF : 36'hF_FFFF_FFFF;
  sequence sel_edge_s;
    $rose(in_clk_i) && !write_port_select_n_i && !write_busy_o;
  endsequence
  sequence desel_edge_s;
    $rose(in_clk_i) && write_port_select_n_i && !write_busy_o;
  endsequence
  sequence pop_mid_s;
    word_valid_o && word_ready_i && word_beat_o != 2'h3;
  endsequence
  busy_start_a: assert property (sel_edge_s |-> ##[1:5] write_busy_o)
    else $error("write did not start");
  desel_idle_a: assert property (desel_edge_s |=> !write_busy_o [*5])
    else $error("deselected edge started a write");
  busy_len_a: assert property ($rose(write_busy_o) |-> write_busy_o [*8])
    else $error("burst ended too soon");
  zero_data_a: assert property (word_valid_o |->
    (word_data_o & ~word_bit_enable_o) == 36'h0)
    else $error("masked bits not cleared");
  lane_limit_a: assert property (word_valid_o |->
    (word_bit_enable_o & ~lim) == 36'h0)
    else $error("enable outside configured width");
  head_hold_a: assert property (word_valid_o && !word_ready_i |=> word_valid_o
    && $stable(word_data_o) && $stable(word_bit_enable_o))
    else $error("head word changed while stalled");
  beat_seq_a: assert property (pop_mid_s |=> !word_valid_o
    || word_beat_o == $past(word_beat_o) + 2'h1)
    else $error("beat order broken");
  addr_keep_a: assert property (pop_mid_s |=> !word_valid_o || $stable(word_addr_o))
    else $error("address changed within burst");
endmodule

// ### verification/wr_ctrl_model.sv
`timescale 1ns/100ps
module wr_ctrl_model (
  input  wire logic        ref_clk_i,
  output logic             in_clk_o,
  output logic             in_clk_n_o,
  output logic             sel_n_o,
  output logic [19:0]      addr_o,
  output logic [35:0]      data_o,
  output logic [1:0]       nib_o,
  output logic [3:0]       lane_o
);
  initial begin
    in_clk_o = 1'b0;
    in_clk_n_o = 1'b1;
    sel_n_o = 1'b1;
    addr_o = 20'h0;
    data_o = 36'h0;
    nib_o = 2'h0;
    lane_o = 4'h0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic flip();
    in_clk_o <= ~in_clk_o;
    in_clk_n_o <= ~in_clk_n_o;
  endtask
  // Pins change mid half period, so they stay still three cycles on each side of every edge but the closing one.
  // With cnt above one the select drops again on every last beat but the final one to chain the next burst.
  task automatic burst(input logic sel, input logic [19:0] a, input logic [143:0] d,
                       input logic [7:0] n, input logic [15:0] l, input int cnt);
    hold(1);
    sel_n_o <= sel;
    addr_o <= a;
    hold(3);
    flip();
    for (int k = 0; k < 4 * cnt; k++) begin
      hold(3);
      if (k % 4 == 3 && k < 4 * cnt - 1) begin
        sel_n_o <= sel;
        addr_o <= a + 20'h0_0010 * 20'(k / 4 + 1);
      end else begin
        sel_n_o <= 1'b1;
        addr_o <= ~a;
      end
      data_o <= d[36*(k%4) +: 36];
      nib_o <= n[2*(k%4) +: 2];
      lane_o <= l[4*(k%4) +: 4];
      hold(3);
      flip();
    end
    hold(3);
    data_o <= ~data_o;
    nib_o <= ~nib_o;
    lane_o <= ~lane_o;
    flip();
    hold(4);
  endtask
endmodule

// ### verification/sram_write_port_masking_tb.sv
`timescale 1ns/100ps
module sram_write_port_masking_tb;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic in_clk_i, in_clk_n_i, write_port_select_n_i;
  logic [19:0] addr_i, word_addr_o;
  logic [35:0] data_i, word_data_o, word_bit_enable_o;
  logic [1:0] nibble_write_mask_n_i, word_beat_o;
  logic [3:0] byte_lane_write_mask_n_i;
  logic [1:0] width_cfg_i = 2'h3;
  logic word_ready_i = 1'b1;
  logic word_valid_o, write_busy_o, overrun_o;
  logic [93:0] q[$];
  int miscompares = 0;
  int comparisons = 0;
  int ovr = 0;
  localparam logic [143:0] D = {36'h9_8765_4321, 36'hF_EDCB_A987,
                                36'h5_A5A5_A5A5, 36'hC_3C3C_3C3C};
  localparam logic [7:0] N = 8'hE4;
  localparam logic [15:0] L = 16'h6A50;
  always #20 ref_clk_i = ~ref_clk_i;
  sram_write_port_masking dut (.ref_clk_i, .rst_n_i, .in_clk_i, .in_clk_n_i,
    .write_port_select_n_i, .addr_i, .data_i, .nibble_write_mask_n_i,
    .byte_lane_write_mask_n_i, .width_cfg_i, .word_valid_o, .word_ready_i, .word_addr_o,
    .word_beat_o, .word_data_o, .word_bit_enable_o, .write_busy_o, .overrun_o);
  wr_ctrl_model ctrl (.ref_clk_i, .in_clk_o(in_clk_i), .in_clk_n_o(in_clk_n_i),
    .sel_n_o(write_port_select_n_i), .addr_o(addr_i), .data_o(data_i),
    .nib_o(nibble_write_mask_n_i), .lane_o(byte_lane_write_mask_n_i));
  always @(posedge ref_clk_i) begin
    if (word_valid_o === 1'b1 && word_ready_i === 1'b1)
      q.push_back({word_addr_o, word_beat_o, word_data_o, word_bit_enable_o});
    if (overrun_o === 1'b1)
      ovr++;
  end
  function automatic logic [35:0] en_of(input logic [1:0] c, input logic [1:0] n,
                                        input logic [3:0] l);
    logic [35:0] e;
    for (int i = 0; i < 36; i++)
      e[i] = ~l[i/9];
    if (c == 2'h0)
      e = {28'h0, {4{~n[1]}}, {4{~n[0]}}};
    else if (c != 2'h3)
      e = e & ((c == 2'h1) ? 36'h0_0000_01FF : 36'h0_0003_FFFF);
    return e;
  endfunction
  task automatic cmp(input logic [93:0] got, input logic [93:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_burst(input logic [1:0] c, input logic [19:0] a);
    logic [35:0] e;
    for (int t = 0; t < 200 && q.size() < 4; t++)
      @(posedge ref_clk_i);
    for (int k = 0; k < 4; k++) begin
      e = en_of(c, N[2*k +: 2], L[4*k +: 4]);
      cmp(q.size() > 0 ? q.pop_front() : 94'h0, {a, 2'(k), D[36*k +: 36] & e, e});
    end
  endtask
  task automatic test_lanes();
    for (int c = 1; c < 4; c++) begin
      width_cfg_i <= 2'(c);
      ctrl.burst(1'b0, 20'(20'h1_2340 + c), D, N, L, 1);
      check_burst(2'(c), 20'(20'h1_2340 + c));
    end
    $display("test lanes done");
  endtask
  task automatic test_nibble();
    width_cfg_i <= 2'h0;
    ctrl.burst(1'b0, 20'hA_BCDE, D, N, L, 1);
    check_burst(2'h0, 20'hA_BCDE);
    width_cfg_i <= 2'h3;
    $display("test nibble done");
  endtask
  // Two bursts joined: the second select shares the edge of the first burst's last beat.
  task automatic test_chain();
    ctrl.burst(1'b0, 20'h3_0000, D, N, L, 2);
    check_burst(2'h3, 20'h3_0000);
    check_burst(2'h3, 20'h3_0010);
    $display("test chain done");
  endtask
  task automatic test_deselect();
    ctrl.burst(1'b1, 20'h5_5555, D, N, L, 1);
    ctrl.hold(20);
    cmp(94'(q.size()), 94'h0);
    $display("test deselect done");
  endtask
  // Three bursts against a stalled consumer: eight words queue, one waits, three are lost.
  task automatic test_fill();
    word_ready_i <= 1'b0;
    for (int b = 0; b < 3; b++)
      ctrl.burst(1'b0, 20'(20'h0_0100 + b), D, N, L, 1);
    ctrl.hold(20);
    cmp(94'(ovr), 94'h3);
    word_ready_i <= 1'b1;
    check_burst(2'h3, 20'h0_0100);
    ctrl.hold(30);
    cmp(94'(q.size()), 94'h5);
    q.delete();
    $display("test fill done");
  endtask
  task automatic close_out();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    test_lanes();
    test_nibble();
    test_chain();
    test_deselect();
    test_fill();
    close_out();
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    miscompares++;
    close_out();
  end
endmodule
bind sram_write_port_masking wr_port_props chk (.ref_clk_i, .rst_n_i, .in_clk_i,
  .write_port_select_n_i, .width_cfg_i, .word_valid_o, .word_ready_i, .word_addr_o,
  .word_beat_o, .word_data_o, .word_bit_enable_o, .write_busy_o);
